// ### pkg/ecfg_regs.svh
// register offsets, field positions, reset values and frame constants of the port config bank
// assumes inclusion by bare name from the design file and both bench files
`ifndef ECFG_REGS_SVH
`define ECFG_REGS_SVH

// ************************************************************
// management frame
// ************************************************************
`define ECFG_PHY_ADDR 5'h17
`define ECFG_PREAMBLE_LEN 6'h20
`define ECFG_OP_READ 2'h2
`define ECFG_OP_WRITE 2'h1

// ************************************************************
// register offsets
// ************************************************************
`define ECFG_REG_RX_DRIVE 5'h0B
`define ECFG_REG_RSVD_A 5'h0C
`define ECFG_REG_RSVD_B 5'h0D
`define ECFG_REG_MISC 5'h0E
`define ECFG_REG_ADDR_LOW 5'h19
`define ECFG_REG_ADDR_HIGH 5'h1A
`define ECFG_REG_ADDR_LAST 5'h1B
`define ECFG_REG_CONTROL 5'h1D
`define ECFG_REG_ABILITY 5'h1E
`define ECFG_REG_SEGMENT 5'h1F

// ************************************************************
// field positions
// ************************************************************
`define ECFG_TRANSMIT_CLOCK_INVERT_BIT 14
`define ECFG_RECEIVE_CLOCK_INVERT_BIT 10
`define ECFG_ROLE_BIT 7
`define ECFG_DUPLEX_BIT 6
`define ECFG_TX_PAUSE_BIT 5
`define ECFG_RX_PAUSE_BIT 4
`define ECFG_DISPLAY_BIT 15
`define ECFG_VALID_BIT 13
`define ECFG_LINK_BIT 12
`define ECFG_LPI_GIG_BIT 11
`define ECFG_LPI_FAST_BIT 10
`define ECFG_PAUSE_CAP_BIT 9
`define ECFG_SEG_SEL_BIT 2

// ************************************************************
// reset values
// ************************************************************
`define ECFG_RX_DRIVE_RST 3'h3
`define ECFG_ADDR_LOW_RST 16'hBA98
`define ECFG_ADDR_HIGH_RST 16'hFEDC
`define ECFG_ADDR_LAST_RST 4'h1
`define ECFG_ABILITY_RST 5'h1F
`define ECFG_DLY_STRAP_HIGH 2'h2
`define ECFG_DLY_STRAP_LOW 2'h0
`define ECFG_SPEED_GIG 2'h2
`define ECFG_SPEED_FAST 2'h1
`define ECFG_MODE_MII 2'h2
`define ECFG_MODE_RGMII 2'h3

`endif

// ### pkg/ecfg_pkg.sv
// types of the external port configuration bank
// assumes the header of constants is compiled alongside
package ecfg_pkg;

	// ************************************************************
	// frame phases
	// ************************************************************
	typedef enum logic [2:0] {
		PH_PREAMBLE = 3'b000,
		PH_HEADER = 3'b001,
		PH_TURN = 3'b010,
		PH_READ = 3'b011,
		PH_WRITE = 3'b100
	} ecfg_phase_t;

	// ************************************************************
	// whole module state
	// ************************************************************
	typedef struct packed {
		logic mdc_q;
		ecfg_phase_t phase;
		logic [5:0] cnt;
		logic [15:0] shreg;
		logic is_read;
		logic [4:0] reg_addr;
		logic mdio_out;
		logic mdio_oe;
		logic strap_done;
		logic [2:0] rx_clock_pad_strength;
		logic hw_snoop_enable;
		logic snoop_auto_set;
		logic [15:0] addr_low;
		logic [15:0] addr_high;
		logic [3:0] port8_mgmt_addr;
		logic transmit_clock_invert;
		logic [1:0] transmit_clock_delay;
		logic receive_clock_invert;
		logic [1:0] receive_clock_delay;
		logic port_role_select;
		logic acts_as_mac;
		logic force_duplex;
		logic force_tx_pause;
		logic force_rx_pause;
		logic [1:0] force_speed;
		logic [1:0] port_interface_select;
		logic link_display;
		logic lpi_ability_gig;
		logic lpi_ability_fast;
		logic pause_capable;
		logic [4:0] ability;
		logic [3:0] external_transceiver_addr;
		logic rom_segment_select;
		logic strap_segment_state;
	} ecfg_state_t;

endpackage

// ### hw/ecfg_top.sv
// external port configuration bank reached over the management serial interface
// assumes mdc, mdio and straps are synchronous to sys_clk and mdc is well below sys_clk / 2
`timescale 1ns/1ns
`include "ecfg_regs.svh"

module ecfg_top (
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// management serial pins
	input wire logic mdc,
	input wire logic mdio_in,
	output logic mdio_out,
	output logic mdio_oe,
	// straps and live status
	input wire logic strap_tx_delay,
	input wire logic strap_rx_delay,
	input wire logic [1:0] strap_interface,
	input wire logic strap_segment,
	input wire logic link_up,
	input wire logic status_valid,
	// configuration outputs
	output logic [2:0] rx_clock_pad_strength,
	output logic hw_snoop_enable,
	output logic snoop_auto_set,
	output logic [15:0] port_addr_low,
	output logic [15:0] port_addr_high,
	output logic [3:0] port8_mgmt_addr,
	output logic transmit_clock_invert,
	output logic [1:0] transmit_clock_delay,
	output logic receive_clock_invert,
	output logic [1:0] receive_clock_delay,
	output logic port_acts_as_mac,
	output logic force_duplex,
	output logic force_tx_pause,
	output logic force_rx_pause,
	output logic [1:0] force_speed,
	output logic [1:0] port_interface_select,
	output logic link_display,
	output logic lpi_ability_gig,
	output logic lpi_ability_fast,
	output logic pause_capable,
	output logic [4:0] ability,
	output logic [3:0] external_transceiver_addr,
	output logic rom_segment_select,
	output logic strap_segment_state
);

	// ************************************************************
	// read data assembly
	// ************************************************************
	function automatic logic [15:0] read_word(input ecfg_pkg::ecfg_state_t s,
			input logic [4:0] a, input logic lu, input logic sv);
		logic [15:0] w;
		w = 16'h0000;
		unique case (a)
			`ECFG_REG_RX_DRIVE: w[2:0] = s.rx_clock_pad_strength;
			`ECFG_REG_MISC: w[0] = s.hw_snoop_enable;
			`ECFG_REG_ADDR_LOW: w = s.addr_low;
			`ECFG_REG_ADDR_HIGH: w = s.addr_high;
			`ECFG_REG_ADDR_LAST: w[3:0] = s.port8_mgmt_addr;
			`ECFG_REG_CONTROL: begin
				w[`ECFG_TRANSMIT_CLOCK_INVERT_BIT] = s.transmit_clock_invert;
				w[13:12] = s.transmit_clock_delay;
				w[`ECFG_RECEIVE_CLOCK_INVERT_BIT] = s.receive_clock_invert;
				w[9:8] = s.receive_clock_delay;
				w[`ECFG_ROLE_BIT] = s.port_role_select;
				w[`ECFG_DUPLEX_BIT] = s.force_duplex;
				w[`ECFG_TX_PAUSE_BIT] = s.force_tx_pause;
				w[`ECFG_RX_PAUSE_BIT] = s.force_rx_pause;
				w[3:2] = s.force_speed;
				w[1:0] = s.port_interface_select;
			end
			`ECFG_REG_ABILITY: begin
				w[`ECFG_DISPLAY_BIT] = s.link_display;
				w[`ECFG_VALID_BIT] = sv;
				w[`ECFG_LINK_BIT] = lu;
				w[`ECFG_LPI_GIG_BIT] = s.lpi_ability_gig;
				w[`ECFG_LPI_FAST_BIT] = s.lpi_ability_fast;
				w[`ECFG_PAUSE_CAP_BIT] = s.pause_capable;
				w[8:4] = s.ability;
				w[3:0] = s.external_transceiver_addr;
			end
			`ECFG_REG_SEGMENT: begin
				w[`ECFG_SEG_SEL_BIT] = s.rom_segment_select;
				w[0] = s.strap_segment_state;
			end
			default: w = 16'h0000;
		endcase
		return w;
	endfunction

	// ************************************************************
	// state
	// ************************************************************
	ecfg_pkg::ecfg_state_t q;
	ecfg_pkg::ecfg_state_t d;
	logic mdc_rise;
	logic [15:0] wdata;
	logic [15:0] hdr;

	assign mdc_rise = mdc & ~q.mdc_q;
	assign wdata = {q.shreg[14:0], mdio_in};
	assign hdr = {q.shreg[14:0], mdio_in};

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		d = q;
		d.mdc_q = mdc;
		d.snoop_auto_set = 1'b0;
		// straps are caught once, in the first cycle after reset release
		if (!q.strap_done) begin
			d.strap_done = 1'b1;
			d.transmit_clock_delay = strap_tx_delay ? `ECFG_DLY_STRAP_HIGH
				: `ECFG_DLY_STRAP_LOW;
			d.receive_clock_delay = strap_rx_delay ? `ECFG_DLY_STRAP_HIGH
				: `ECFG_DLY_STRAP_LOW;
			d.port_interface_select = strap_interface;
			d.force_speed = (strap_interface == `ECFG_MODE_RGMII) ? `ECFG_SPEED_GIG
				: `ECFG_SPEED_FAST;
			d.strap_segment_state = strap_segment;
		end
		if (mdc_rise) begin
			unique case (q.phase)
				ecfg_pkg::PH_PREAMBLE: begin
					if (mdio_in) begin
						if (q.cnt != `ECFG_PREAMBLE_LEN) begin
							d.cnt = q.cnt + 6'h01;
						end
					end else if (q.cnt == `ECFG_PREAMBLE_LEN) begin
						d.phase = ecfg_pkg::PH_HEADER;
						d.cnt = 6'h00;
					end else begin
						d.cnt = 6'h00;
					end
				end
				ecfg_pkg::PH_HEADER: begin
					d.shreg = hdr;
					d.cnt = q.cnt + 6'h01;
					if (q.cnt == 6'h0C) begin
						d.cnt = 6'h00;
						d.reg_addr = hdr[4:0];
						// frames to other addresses are dropped; preamble must come again
						if (hdr[12] && hdr[9:5] == `ECFG_PHY_ADDR
								&& hdr[11:10] == `ECFG_OP_READ) begin
							d.phase = ecfg_pkg::PH_TURN;
							d.is_read = 1'b1;
						end else if (hdr[12] && hdr[9:5] == `ECFG_PHY_ADDR
								&& hdr[11:10] == `ECFG_OP_WRITE) begin
							d.phase = ecfg_pkg::PH_TURN;
							d.is_read = 1'b0;
						end else begin
							d.phase = ecfg_pkg::PH_PREAMBLE;
						end
					end
				end
				ecfg_pkg::PH_TURN: begin
					if (q.cnt == 6'h00) begin
						d.cnt = 6'h01;
						if (q.is_read) begin
							d.mdio_oe = 1'b1;
							d.mdio_out = 1'b0;
						end
					end else begin
						d.cnt = 6'h00;
						if (q.is_read) begin
							d.shreg = read_word(q, q.reg_addr, link_up, status_valid);
							d.mdio_out = d.shreg[15];
							d.phase = ecfg_pkg::PH_READ;
						end else begin
							d.phase = ecfg_pkg::PH_WRITE;
						end
					end
				end
				ecfg_pkg::PH_READ: begin
					d.cnt = q.cnt + 6'h01;
					d.shreg = {q.shreg[14:0], 1'b0};
					d.mdio_out = q.shreg[14];
					if (q.cnt == 6'h0F) begin
						d.mdio_oe = 1'b0;
						d.mdio_out = 1'b0;
						d.cnt = 6'h00;
						d.phase = ecfg_pkg::PH_PREAMBLE;
					end
				end
				ecfg_pkg::PH_WRITE: begin
					d.cnt = q.cnt + 6'h01;
					d.shreg = wdata;
					if (q.cnt == 6'h0F) begin
						d.cnt = 6'h00;
						d.phase = ecfg_pkg::PH_PREAMBLE;
						unique case (q.reg_addr)
							`ECFG_REG_RX_DRIVE: d.rx_clock_pad_strength = wdata[2:0];
							`ECFG_REG_MISC: begin
								d.hw_snoop_enable = wdata[0];
								d.snoop_auto_set = wdata[0];
							end
							`ECFG_REG_ADDR_LOW: d.addr_low = wdata;
							`ECFG_REG_ADDR_HIGH: d.addr_high = wdata;
							`ECFG_REG_ADDR_LAST: d.port8_mgmt_addr = wdata[3:0];
							`ECFG_REG_CONTROL: begin
								d.transmit_clock_invert = wdata[`ECFG_TRANSMIT_CLOCK_INVERT_BIT];
								d.transmit_clock_delay = wdata[13:12];
								d.receive_clock_invert = wdata[`ECFG_RECEIVE_CLOCK_INVERT_BIT];
								d.receive_clock_delay = wdata[9:8];
								d.port_role_select = wdata[`ECFG_ROLE_BIT];
								d.force_duplex = wdata[`ECFG_DUPLEX_BIT];
								d.force_tx_pause = wdata[`ECFG_TX_PAUSE_BIT];
								d.force_rx_pause = wdata[`ECFG_RX_PAUSE_BIT];
								d.force_speed = wdata[3:2];
								d.port_interface_select = wdata[1:0];
							end
							`ECFG_REG_ABILITY: begin
								d.link_display = wdata[`ECFG_DISPLAY_BIT];
								d.lpi_ability_gig = wdata[`ECFG_LPI_GIG_BIT];
								d.lpi_ability_fast = wdata[`ECFG_LPI_FAST_BIT];
								d.pause_capable = wdata[`ECFG_PAUSE_CAP_BIT];
								d.ability = wdata[8:4];
								d.external_transceiver_addr = wdata[3:0];
							end
							`ECFG_REG_SEGMENT: d.rom_segment_select = wdata[`ECFG_SEG_SEL_BIT];
							default: d.cnt = 6'h00;
						endcase
					end
				end
				default: begin
					d.phase = ecfg_pkg::PH_PREAMBLE;
					d.cnt = 6'h00;
					d.mdio_oe = 1'b0;
				end
			endcase
		end
		// role only matters while the port is in mii mode
		d.acts_as_mac = d.port_role_select
			&& d.port_interface_select == `ECFG_MODE_MII;
	end

	// ************************************************************
	// registers
	// ************************************************************
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			q <= '0;
			q.rx_clock_pad_strength <= `ECFG_RX_DRIVE_RST;
			q.addr_low <= `ECFG_ADDR_LOW_RST;
			q.addr_high <= `ECFG_ADDR_HIGH_RST;
			q.port8_mgmt_addr <= `ECFG_ADDR_LAST_RST;
			q.force_duplex <= 1'b1;
			q.force_tx_pause <= 1'b1;
			q.force_rx_pause <= 1'b1;
			q.lpi_ability_gig <= 1'b1;
			q.lpi_ability_fast <= 1'b1;
			q.pause_capable <= 1'b1;
			q.ability <= `ECFG_ABILITY_RST;
		end else begin
			q <= d;
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************
	assign mdio_out = q.mdio_out;
	assign mdio_oe = q.mdio_oe;
	assign rx_clock_pad_strength = q.rx_clock_pad_strength;
	assign hw_snoop_enable = q.hw_snoop_enable;
	assign snoop_auto_set = q.snoop_auto_set;
	assign port_addr_low = q.addr_low;
	assign port_addr_high = q.addr_high;
	assign port8_mgmt_addr = q.port8_mgmt_addr;
	assign transmit_clock_invert = q.transmit_clock_invert;
	assign transmit_clock_delay = q.transmit_clock_delay;
	assign receive_clock_invert = q.receive_clock_invert;
	assign receive_clock_delay = q.receive_clock_delay;
	assign port_acts_as_mac = q.acts_as_mac;
	assign force_duplex = q.force_duplex;
	assign force_tx_pause = q.force_tx_pause;
	assign force_rx_pause = q.force_rx_pause;
	assign force_speed = q.force_speed;
	assign port_interface_select = q.port_interface_select;
	assign link_display = q.link_display;
	assign lpi_ability_gig = q.lpi_ability_gig;
	assign lpi_ability_fast = q.lpi_ability_fast;
	assign pause_capable = q.pause_capable;
	assign ability = q.ability;
	assign external_transceiver_addr = q.external_transceiver_addr;
	assign rom_segment_select = q.rom_segment_select;
	assign strap_segment_state = q.strap_segment_state;

	// ************************************************************
	// checks
	// ************************************************************
	chk_speed_from_mode: assert property (@(posedge sys_clk) disable iff (!reset_n)
		$rose(q.strap_done) |-> q.force_speed == ((q.port_interface_select == 2'h3) ? 2'h2 : 2'h1))
		else $error("forced speed reset does not follow interface mode");
	chk_tx_delay_strap: assert property (@(posedge sys_clk) disable iff (!reset_n)
		$rose(q.strap_done) |-> q.transmit_clock_delay == ($past(strap_tx_delay) ? 2'h2 : 2'h0))
		else $error("transmit delay not loaded from strap");
	chk_rx_delay_strap: assert property (@(posedge sys_clk) disable iff (!reset_n)
		$rose(q.strap_done) |-> q.receive_clock_delay == ($past(strap_rx_delay) ? 2'h2 : 2'h0))
		else $error("receive delay not loaded from strap");
	chk_mode_strap: assert property (@(posedge sys_clk) disable iff (!reset_n)
		$rose(q.strap_done) |-> q.port_interface_select == $past(strap_interface))
		else $error("interface mode not loaded from straps");
	chk_snoop_pulse: assert property (@(posedge sys_clk) disable iff (!reset_n)
		q.snoop_auto_set |-> q.hw_snoop_enable && $past(q.phase) == ecfg_pkg::PH_WRITE
			##1 !q.snoop_auto_set)
		else $error("snoop setup pulse without a write of one");
	chk_mac_role: assert property (@(posedge sys_clk) disable iff (!reset_n)
		port_acts_as_mac |-> port_interface_select == 2'h2)
		else $error("mac role active outside mii mode");
	chk_turn_drive: assert property (@(posedge sys_clk) disable iff (!reset_n)
		q.phase == ecfg_pkg::PH_TURN && q.is_read && mdc_rise && q.cnt == 6'h00
			|=> mdio_oe && !mdio_out)
		else $error("read turnaround zero not driven");
	chk_read_release: assert property (@(posedge sys_clk) disable iff (!reset_n)
		q.phase == ecfg_pkg::PH_READ && mdc_rise && q.cnt == 6'h0F |=> !mdio_oe)
		else $error("mdio not released after read data");
	chk_reserved_zero: assert property (@(posedge sys_clk) disable iff (!reset_n)
		$rose(q.phase == ecfg_pkg::PH_READ) && (q.reg_addr == 5'h0C || q.reg_addr == 5'h0D)
			|-> q.shreg == 16'h0000)
		else $error("reserved register read is not zero");
	chk_strength_reset: assert property (@(posedge sys_clk) disable iff (!reset_n)
		$rose(q.strap_done) |-> rx_clock_pad_strength == `ECFG_RX_DRIVE_RST)
		else $error("pad strength not at its reset value");
	chk_addr_resets: assert property (@(posedge sys_clk) disable iff (!reset_n)
		$rose(q.strap_done) |-> port_addr_high == `ECFG_ADDR_HIGH_RST && port8_mgmt_addr == 4'h1)
		else $error("port addresses not at their reset values");
	chk_force_resets: assert property (@(posedge sys_clk) disable iff (!reset_n)
		$rose(q.strap_done) |-> force_duplex && force_tx_pause && force_rx_pause)
		else $error("forced duplex or pause bits not set after reset");
	chk_ability_resets: assert property (@(posedge sys_clk) disable iff (!reset_n)
		$rose(q.strap_done) |-> ability == `ECFG_ABILITY_RST && pause_capable
			&& lpi_ability_gig && lpi_ability_fast)
		else $error("ability bits not set after reset");
	chk_misc_write: assert property (@(posedge sys_clk) disable iff (!reset_n)
		q.phase == ecfg_pkg::PH_WRITE && mdc_rise && q.cnt == 6'h0F
			&& q.reg_addr == `ECFG_REG_MISC |=> snoop_auto_set == hw_snoop_enable)
		else $error("snoop setup pulse does not follow the written bit");
	chk_addr_write: assert property (@(posedge sys_clk) disable iff (!reset_n)
		q.phase == ecfg_pkg::PH_WRITE && mdc_rise && q.cnt == 6'h0F
			&& q.reg_addr == `ECFG_REG_ADDR_LOW |=> port_addr_low == $past(wdata))
		else $error("low port address write did not land");
	chk_foreign_frame: assert property (@(posedge sys_clk) disable iff (!reset_n)
		q.phase == ecfg_pkg::PH_HEADER && mdc_rise && q.cnt == 6'h0C
			&& hdr[9:5] != `ECFG_PHY_ADDR |=> q.phase == ecfg_pkg::PH_PREAMBLE && !mdio_oe)
		else $error("frame to another address was not dropped");
	chk_segment_fixed: assert property (@(posedge sys_clk) disable iff (!reset_n)
		q.strap_done |=> $stable(strap_segment_state))
		else $error("strapped segment changed after capture");

endmodule // ecfg_top

// ### tb/ecfg_mgmt_master.sv
// management serial master that stands in for the external controller
// assumes the bench resolves the shared data line, with a pull-up, from both enables
`timescale 1ns/1ns
`include "ecfg_regs.svh"

module ecfg_mgmt_master (
	// clock
	input wire logic sys_clk,
	// management pins
	output logic mdc,
	output logic mdio_drv,
	output logic mdio_drv_oe,
	input wire logic mdio_wire,
	input wire logic dut_oe
);
	// half period of mdc in sys_clk cycles, set by the bench for fast or slow frames
	int half = 2;

	initial begin
		mdc = 1'b0;
		mdio_drv = 1'b1;
		mdio_drv_oe = 1'b0;
	end

	// ************************************************************
	// one bit: drive while mdc is low, sample just before the rise
	// ************************************************************
	task automatic bit_cycle(input logic drive, input logic val, output logic smp);
		mdc <= 1'b0;
		mdio_drv_oe <= drive;
		mdio_drv <= val;
		repeat (half) @(posedge sys_clk);
		smp = mdio_wire;
		mdc <= 1'b1;
		repeat (half) @(posedge sys_clk);
	endtask

	// ************************************************************
	// whole frame, own preamble every time
	// ************************************************************
	task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] rg,
		input logic [15:0] wd, output logic [15:0] rd, output logic drove);
		logic [13:0] hdr;
		logic s;
		hdr = {2'b01, op, phy, rg};
		drove = 1'b0;
		rd = 16'h0000;
		for (int i = 0; i < 32; i++) bit_cycle(1'b1, 1'b1, s);
		for (int i = 13; i >= 0; i--) bit_cycle(1'b1, hdr[i], s);
		if (op == `ECFG_OP_READ) begin
			bit_cycle(1'b0, 1'b1, s);
			bit_cycle(1'b0, 1'b1, s);
			for (int i = 15; i >= 0; i--) begin
				bit_cycle(1'b0, 1'b1, s);
				rd[i] = s;
				drove = drove | dut_oe;
			end
		end else begin
			bit_cycle(1'b1, 1'b1, s);
			bit_cycle(1'b1, 1'b0, s);
			for (int i = 15; i >= 0; i--) bit_cycle(1'b1, wd[i], s);
		end
		// idle bit lets the last write land before anyone looks
		bit_cycle(1'b0, 1'b1, s);
		// park mdc low so a reset between frames sees no false rise
		mdc <= 1'b0;
		@(posedge sys_clk);
	endtask
endmodule // ecfg_mgmt_master

// ### tb/ecfg_top_tb_top.sv
// self-checking bench of the port configuration bank against a register model
// assumes the management master partner and the design header are compiled alongside
`timescale 1ns/1ns
`include "ecfg_regs.svh"

module ecfg_top_tb_top;
	logic sys_clk, reset_n, mdc, mdio_wire, mdio_out, mdio_oe, m_drv, m_oe;
	logic strap_tx_delay, strap_rx_delay, strap_segment, link_up, status_valid;
	logic [1:0] strap_interface, transmit_clock_delay, receive_clock_delay;
	logic [1:0] force_speed, port_interface_select;
	logic [2:0] rx_clock_pad_strength;
	logic [3:0] port8_mgmt_addr, external_transceiver_addr;
	logic [4:0] ability;
	logic [15:0] port_addr_low, port_addr_high;
	logic hw_snoop_enable, snoop_auto_set, transmit_clock_invert, receive_clock_invert;
	logic port_acts_as_mac, force_duplex, force_tx_pause, force_rx_pause, link_display;
	logic lpi_ability_gig, lpi_ability_fast, pause_capable, rom_segment_select;
	logic strap_segment_state;
	logic [68:0] outs;
	logic [15:0] m [0:31];
	int n_fail = 0, n_compared = 0, n_pulse = 0, exp_pulse = 0;
	int regs[$] = '{11, 12, 13, 14, 25, 26, 27, 29, 30, 31, 16};

	// pull-up on the shared data line
	assign mdio_wire = mdio_oe ? mdio_out : (m_oe ? m_drv : 1'b1);
	assign outs = {rx_clock_pad_strength, hw_snoop_enable, port_addr_low, port_addr_high,
		port8_mgmt_addr, transmit_clock_invert, transmit_clock_delay, receive_clock_invert,
		receive_clock_delay, port_acts_as_mac, force_duplex, force_tx_pause, force_rx_pause,
		force_speed, port_interface_select, link_display, lpi_ability_gig, lpi_ability_fast,
		pause_capable, ability, external_transceiver_addr, rom_segment_select,
		strap_segment_state};

	ecfg_top dut (.sys_clk, .reset_n, .mdc, .mdio_in(mdio_wire), .mdio_out, .mdio_oe,
		.strap_tx_delay, .strap_rx_delay, .strap_interface, .strap_segment, .link_up,
		.status_valid, .rx_clock_pad_strength, .hw_snoop_enable, .snoop_auto_set,
		.port_addr_low, .port_addr_high, .port8_mgmt_addr, .transmit_clock_invert,
		.transmit_clock_delay, .receive_clock_invert, .receive_clock_delay, .port_acts_as_mac,
		.force_duplex, .force_tx_pause, .force_rx_pause, .force_speed, .port_interface_select,
		.link_display, .lpi_ability_gig, .lpi_ability_fast, .pause_capable, .ability,
		.external_transceiver_addr, .rom_segment_select, .strap_segment_state);

	ecfg_mgmt_master u_mst (.sys_clk, .mdc, .mdio_drv(m_drv), .mdio_drv_oe(m_oe),
		.mdio_wire, .dut_oe(mdio_oe));

	always #4 sys_clk = ~sys_clk;

	// counts cycles, so a stretched pulse shows up as an extra count
	always @(negedge sys_clk) begin
		if (snoop_auto_set === 1'b1) n_pulse++;
	end

	// ************************************************************
	// model
	// ************************************************************
	function automatic logic [15:0] wmask(input int r);
		case (r)
			11: return 16'h0007;
			14: return 16'h0001;
			25, 26: return 16'hFFFF;
			27: return 16'h000F;
			29: return 16'h77FF;
			30: return 16'h8FFF;
			31: return 16'h0004;
			default: return 16'h0000;
		endcase
	endfunction

	function automatic logic [68:0] exp_outs();
		logic [15:0] c;
		logic [15:0] a;
		c = m[29];
		a = m[30];
		return {m[11][2:0], m[14][0], m[25], m[26], m[27][3:0], c[14], c[13:12], c[10], c[9:8],
			c[7] & (c[1:0] == 2'h2), c[6:4], c[3:2], c[1:0], a[15], a[11:9], a[8:4], a[3:0],
			m[31][2], m[31][0]};
	endfunction

	task automatic check(input logic [68:0] got, input logic [68:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic summarize();
		$display("compared %0d mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic op(input logic [1:0] code, input logic [4:0] phy, input int r,
		input logic [15:0] wd);
		logic [15:0] rd;
		logic [15:0] ev;
		logic dr;
		logic ok;
		ok = (phy == 5'h17);
		ev = m[r] | ((r == 30) ? {2'b00, status_valid, link_up, 12'h000} : 16'h0000);
		u_mst.frame(code, phy, r[4:0], wd, rd, dr);
		if (ok && code == 2'h1) begin
			m[r] = (m[r] & ~wmask(r)) | (wd & wmask(r));
			if (r == 14 && wd[0]) exp_pulse++;
		end
		if (code == 2'h2) check({52'h0, dr, rd}, {52'h0, ok, ok ? ev : 16'hFFFF});
		check(outs, exp_outs());
		check(69'(n_pulse), 69'(exp_pulse));
	endtask

	task automatic do_reset(input int i);
		@(posedge sys_clk);
		reset_n <= 1'b0;
		strap_tx_delay <= i[0];
		strap_rx_delay <= ~i[0];
		strap_interface <= i[1:0];
		strap_segment <= i[1];
		repeat (4) @(posedge sys_clk);
		reset_n <= 1'b1;
		repeat (2) @(posedge sys_clk);
		foreach (m[k]) m[k] = 16'h0000;
		m[11] = 16'h0003;
		m[25] = 16'hBA98;
		m[26] = 16'hFEDC;
		m[27] = 16'h0001;
		m[29] = {2'b00, i[0] ? 2'h2 : 2'h0, 2'b00, i[0] ? 2'h0 : 2'h2, 4'h7,
			(i[1:0] == 2'h3) ? 2'h2 : 2'h1, i[1:0]};
		m[30] = 16'h0FF0;
		m[31] = {15'h0000, i[1]};
	endtask

	// ************************************************************
	// sequence
	// ************************************************************
	initial begin
		sys_clk = 1'b0;
		reset_n = 1'b0;
		{strap_tx_delay, strap_rx_delay, strap_segment, link_up, status_valid} = 5'h00;
		strap_interface = 2'h0;
		void'($urandom(32'h30A68CAA));
		for (int i = 0; i < 4; i++) begin
			do_reset(i);
			check(outs, exp_outs());
			foreach (regs[k]) op(2'h2, 5'h17, regs[k], 16'h0000);
		end
		for (int md = 0; md < 4; md++) op(2'h1, 5'h17, 29, 16'h0080 | 16'(md));
		for (int s = 0; s < 3; s++) op(2'h1, 5'h17, 14, {15'h0000, s != 1});
		op(2'h1, 5'h16, 25, 16'h1234);
		op(2'h2, 5'h16, 25, 16'h0000);
		op(2'h0, 5'h17, 25, 16'h5678);
		op(2'h3, 5'h17, 25, 16'h9ABC);
		op(2'h2, 5'h17, 25, 16'h0000);
		for (int rnd = 0; rnd < 3; rnd++) begin
			u_mst.half = 2 + rnd % 2;
			@(posedge sys_clk);
			link_up <= $urandom % 2;
			status_valid <= $urandom % 2;
			foreach (regs[k]) begin
				op(2'h1, 5'h17, regs[k], 16'($urandom));
				op(2'h2, 5'h17, regs[k], 16'h0000);
			end
		end
		summarize();
	end

	// hang guard: a run this long is itself a mismatch
	initial begin
		repeat (90000) @(posedge sys_clk);
		n_fail++;
		summarize();
	end
endmodule // ecfg_top_tb_top
